// [hw/synth_serial_program_port.sv]
// serial programming port, register bank and digital lock detect
`timescale 1ns/1ps
module synth_serial_program_port (
   input wire logic sys_clk, // 200 MHz system clock
   input wire logic rstn, // async reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic serial_clk, // serial clock pin
   input wire logic serial_data, // serial data pin
   input wire logic latch_strobe, // latch strobe pin
   input wire logic phase_detector_clk, // detector reference pin
   input wire logic [7:0] phase_error_ns, // error per detector cycle
   output logic status_output_pin, // selected status signal
   output logic lock_detect, // digital lock indication
   output logic fast_lock, // one-cycle fast lock start pulse
   output synth_prog_pkg::divider_cfg_t divider_cfg, // applied settings
   output logic prescaler_sel, // prescaler choice
   output logic [8:0] timeout_count, // fast lock timer count
   output logic [1:0] timer_sel, // fast lock timer select
   output logic [4:0] powerdown_ctl, // power-down controls
   output logic [23:0] function_word // function register bits
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] s1_q, s2_q, s3_q;
   logic [3:0] s1_d, s2_d, s3_d;
   always_comb begin
      s1_d = {phase_detector_clk, latch_strobe, serial_data, serial_clk};
      s2_d = s1_q;
      s3_d = s2_q;
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end else if (clk_en) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   logic sclk_rise, le_rise, pd_rise, sdata;
   assign sclk_rise = s2_q[0] & ~s3_q[0];
   assign sdata = s2_q[1];
   assign le_rise = s2_q[2] & ~s3_q[2];
   assign pd_rise = s2_q[3] & ~s3_q[3];

   // ---------------------------------------------------------------
   // shift register and register bank
   // ---------------------------------------------------------------
   logic [23:0] shift_q, shift_d;
   logic [23:0] bank_q [8];
   logic [23:0] bank_d [8];
   logic [2:0] sel;
   logic freq_written_q, freq_written_d;
   synth_prog_pkg::divider_cfg_t cfg_q, cfg_d;
   assign sel = shift_q[2:0];
   always_comb begin
      shift_d = shift_q;
      if (sclk_rise) begin
         shift_d = {shift_q[22:0], sdata};
      end
   end
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bank
         always_comb begin
            bank_d[g] = bank_q[g];
            if (le_rise && sel == 3'(g)) begin
               bank_d[g] = shift_q;
            end
         end
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               bank_q[g] <= synth_prog_pkg::WORD_RST;
            end else if (clk_en) begin
               bank_q[g] <= bank_d[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // shadow transfer: a frequency write applies staged fields
   // ---------------------------------------------------------------
   logic [23:0] mw, pw, fq;
   logic freq_commit;
   // staged words are snapshotted at the frequency commit, so a modulus
   // or phase write before the next detector edge cannot leak in
   logic [23:0] mod_snap_q, mod_snap_d, ph_snap_q, ph_snap_d;
   assign freq_commit = le_rise && sel == synth_prog_pkg::SEL_FREQ;
   assign mw = bank_q[synth_prog_pkg::SEL_MODREF];
   assign pw = bank_q[synth_prog_pkg::SEL_PHASE];
   assign fq = bank_q[synth_prog_pkg::SEL_FREQ];
   always_comb begin
      freq_written_d = freq_written_q;
      cfg_d = cfg_q;
      mod_snap_d = mod_snap_q;
      ph_snap_d = ph_snap_q;
      if (freq_commit) begin
         freq_written_d = 1'b1;
         mod_snap_d = mw;
         ph_snap_d = pw;
      end else if (pd_rise && freq_written_q) begin
         // divider picks up new values on the next detector cycle
         freq_written_d = 1'b0;
         cfg_d.int_value =
            fq[synth_prog_pkg::INT_MSB:synth_prog_pkg::INT_LSB];
         cfg_d.fraction_numerator =
            fq[synth_prog_pkg::FRACTION_NUMERATOR_MSB:synth_prog_pkg::FRACTION_NUMERATOR_LSB];
         cfg_d.fraction_modulus =
            mod_snap_q[synth_prog_pkg::FRACTION_NUMERATOR_MSB:synth_prog_pkg::FRACTION_NUMERATOR_LSB];
         cfg_d.ref_count =
            mod_snap_q[synth_prog_pkg::RCNT_MSB:synth_prog_pkg::RCNT_LSB];
         cfg_d.pump_boost = mod_snap_q[synth_prog_pkg::BOOST_BIT];
         cfg_d.ref_halve = mod_snap_q[synth_prog_pkg::HALVE_BIT];
         cfg_d.doubler = mod_snap_q[synth_prog_pkg::DOUBLER_BIT];
         cfg_d.phase =
            ph_snap_q[synth_prog_pkg::PHASE_MSB:synth_prog_pkg::PHASE_LSB];
      end
   end
   logic fast_lock_d;
   // a commit in the same cycle wins, so the pulse waits with the load
   assign fast_lock_d = pd_rise && freq_written_q && !freq_commit;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shift_q <= synth_prog_pkg::WORD_RST;
         freq_written_q <= 1'b0;
         cfg_q <= '0;
         fast_lock <= 1'b0;
         mod_snap_q <= synth_prog_pkg::WORD_RST;
         ph_snap_q <= synth_prog_pkg::WORD_RST;
      end else if (clk_en) begin
         shift_q <= shift_d;
         freq_written_q <= freq_written_d;
         cfg_q <= cfg_d;
         fast_lock <= fast_lock_d;
         mod_snap_q <= mod_snap_d;
         ph_snap_q <= ph_snap_d;
      end
   end
   assign divider_cfg = cfg_q;
   assign prescaler_sel = mw[synth_prog_pkg::PRESC_BIT];
   assign timeout_count =
      bank_q[4][synth_prog_pkg::TMO_MSB:synth_prog_pkg::TMO_LSB];
   assign timer_sel =
      bank_q[4][synth_prog_pkg::TSEL_MSB:synth_prog_pkg::TSEL_LSB];
   assign powerdown_ctl = bank_q[5][7:3];
   assign function_word = bank_q[3];

   // ---------------------------------------------------------------
   // lock detect, evaluated once per detector cycle
   // ---------------------------------------------------------------
   logic [7:0] err_q, err_d;
   logic [5:0] good_q, good_d;
   logic lock_q, lock_d;
   logic [7:0] thr;
   logic [23:0] ow;
   assign ow = bank_q[synth_prog_pkg::SEL_OSEL];
   // raised threshold bit lets host loosen detection at low frequency
   assign thr = ow[synth_prog_pkg::THR_BIT] ?
      synth_prog_pkg::ERR_LOOSE_NS : synth_prog_pkg::ERR_TIGHT_NS;
   // each decision uses the error captured at the previous detector edge,
   // so a large error drops lock one detector cycle after it appears
   always_comb begin
      err_d = err_q;
      good_d = good_q;
      lock_d = lock_q;
      if (pd_rise) begin
         err_d = phase_error_ns;
      end
      if (freq_commit) begin
         good_d = 6'h00;
         lock_d = 1'b0;
      end else if (pd_rise) begin
         if (err_q > synth_prog_pkg::ERR_UNLOCK_NS) begin
            lock_d = 1'b0;
            good_d = 6'h00;
         end else if (err_q < thr) begin
            if (good_q != 6'(synth_prog_pkg::LOCK_CYCLES)) begin
               good_d = good_q + 6'h01;
            end
            if (good_q >= 6'(synth_prog_pkg::LOCK_CYCLES - 1)) begin
               lock_d = 1'b1;
            end
         end else begin
            good_d = 6'h00;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         err_q <= 8'hff;
         good_q <= 6'h00;
         lock_q <= 1'b0;
      end else if (clk_en) begin
         err_q <= err_d;
         good_q <= good_d;
         lock_q <= lock_d;
      end
   end
   assign lock_detect = lock_q;

   // ---------------------------------------------------------------
   // status output select
   // ---------------------------------------------------------------
   logic stat_d, stat_q;
   always_comb begin
      case (ow[synth_prog_pkg::OSEL_MSB:synth_prog_pkg::OSEL_LSB])
         synth_prog_pkg::OSRC_LOCK: stat_d = lock_q;
         synth_prog_pkg::OSRC_HIGH: stat_d = 1'b1;
         default: stat_d = 1'b0;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stat_q <= 1'b0;
      end else if (clk_en) begin
         stat_q <= stat_d;
      end
   end
   assign status_output_pin = stat_q;
endmodule : synth_serial_program_port

// [hw/synth_prog_pkg.sv]
// constants and types for the synthesizer serial programming port
// Functional notes
// - lock detect routable to status output pin
// - lock after 40 cycles error below 3ns, or below 10ns with threshold bit set
// - lock drops on new channel or error above 30ns
// - 24-bit shift register, rising serial clock
// - latch strobe rise commits word to register
// - three LSBs select destination register
// - codes 0..7 map registers in fixed order
// - frequency word: integer 23:15, fraction 14:3
// - modulus word field layout, bit 21 reserved
// - timer word count 13:5, select 4:3
// - marked fields held in shadow stage
// - shadows applied when frequency word written
// - next detector cycle loads divider, fast lock
// - output select field bits 6:3 picks source
package synth_prog_pkg;
   // ---------------------------------------------------------------
   // word layout
   // ---------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int SEL_W = 3;
   localparam int INT_MSB = 23;
   localparam int INT_LSB = 15;
   localparam int FRACTION_NUMERATOR_MSB = 14;
   localparam int FRACTION_NUMERATOR_LSB = 3;
   localparam int BOOST_BIT = 23;
   localparam int HALVE_BIT = 22;
   localparam int PRESC_BIT = 20;
   localparam int DOUBLER_BIT = 19;
   localparam int RCNT_MSB = 18;
   localparam int RCNT_LSB = 15;
   localparam int PHASE_MSB = 14;
   localparam int PHASE_LSB = 3;
   localparam int TMO_MSB = 13;
   localparam int TMO_LSB = 5;
   localparam int TSEL_MSB = 4;
   localparam int TSEL_LSB = 3;
   localparam int OSEL_MSB = 6;
   localparam int OSEL_LSB = 3;
   localparam int THR_BIT = 15;
   // ---------------------------------------------------------------
   // select codes and output sources
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_FREQ = 3'h0;
   localparam logic [2:0] SEL_MODREF = 3'h1;
   localparam logic [2:0] SEL_PHASE = 3'h2;
   localparam logic [2:0] SEL_FUNC = 3'h3;
   localparam logic [2:0] SEL_TIMER = 3'h4;
   localparam logic [2:0] SEL_PDOWN = 3'h5;
   localparam logic [2:0] SEL_OSEL = 3'h6;
   localparam logic [2:0] SEL_TEST = 3'h7;
   localparam logic [3:0] OSRC_LOW = 4'h0;
   localparam logic [3:0] OSRC_LOCK = 4'h6;
   localparam logic [3:0] OSRC_HIGH = 4'hf;
   localparam logic [23:0] WORD_RST = 24'h000000;
   // ---------------------------------------------------------------
   // lock detect timing, error measured in ns
   // ---------------------------------------------------------------
   localparam int LOCK_CYCLES = 40;
   localparam logic [7:0] ERR_TIGHT_NS = 8'h03;
   localparam logic [7:0] ERR_LOOSE_NS = 8'h0a;
   localparam logic [7:0] ERR_UNLOCK_NS = 8'h1e;
   // ---------------------------------------------------------------
   // applied divider settings
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [8:0] int_value;
      logic [11:0] fraction_numerator;
      logic [11:0] fraction_modulus;
      logic [3:0] ref_count;
      logic pump_boost;
      logic ref_halve;
      logic doubler;
      logic [11:0] phase;
   } divider_cfg_t;
endpackage : synth_prog_pkg

// [sim/ssp_props.sv]
// assertions on the pins of the serial programming port
`timescale 1ns/1ps
module ssp_props (
   input wire logic sys_clk, // clock
   input wire logic rstn, // reset, active low
   input wire logic clk_en, // clock enable, design frozen while low
   input wire logic latch_strobe, // strobe pin
   input wire logic [7:0] phase_error_ns, // detector error
   input wire logic lock_detect, // lock indication
   input wire logic fast_lock, // fast lock pulse
   input wire synth_prog_pkg::divider_cfg_t divider_cfg, // applied
   input wire logic [8:0] timeout_count, // timer count
   input wire logic [23:0] function_word // function bits
);
   // ---------------------------------------------------------------
   // cycle counters since strobe rise, bad error, and lock low
   // ---------------------------------------------------------------
   logic [7:0] lat_q, lat_d, bad_q, bad_d;
   logic [10:0] low_q, low_d;
   logic seen_q;
   always_comb begin
      lat_d = (latch_strobe && !seen_q) ? 8'h00 : lat_q + {7'h0, ~&lat_q};
      bad_d = (phase_error_ns > 8'h1e) ? 8'h00 : bad_q + {7'h0, ~&bad_q};
      low_d = lock_detect ? 11'h000 : low_q + {10'h0, ~&low_q};
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lat_q <= 8'hff;
         bad_q <= 8'hff;
         low_q <= 11'h000;
         seen_q <= 1'b0;
      end else begin
         lat_q <= lat_d;
         bad_q <= bad_d;
         low_q <= low_d;
         seen_q <= latch_strobe;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   // a frozen design keeps its outputs, so timing rules pause with it
   default disable iff (!rstn || !clk_en);
   AST_FAST_PULSE: assert property (fast_lock |=> !fast_lock [*8])
      else $error("fast lock pulse too long");
   AST_FAST_CAUSE: assert property (fast_lock |-> lat_q < 8'h3c)
      else $error("fast lock without a recent commit");
   AST_LOCK_FAST: assert property (fast_lock |-> !lock_detect)
      else $error("lock held across new channel");
   AST_DIV_FAST: assert property ($changed(divider_cfg) |->
      ##[0:1] (fast_lock || $past(fast_lock)))
      else $error("divider settings moved outside a channel load");
   AST_CFG_HOLD: assert property ($changed(timeout_count) |->
      lat_q < 8'h08) else $error("timer count moved without strobe");
   AST_FUNC_HOLD: assert property ($changed(function_word) |->
      lat_q < 8'h08) else $error("function bits moved without strobe");
   AST_LOCK_MIN: assert property ($rose(lock_detect) |->
      low_q >= 11'h258) else $error("lock came too early");
   AST_UNLOCK_ERR: assert property (lock_detect &&
      phase_error_ns > 8'h1e |-> ##[1:30] !lock_detect)
      else $error("lock kept after large error");
   AST_FELL_CAUSE: assert property ($fell(lock_detect) |->
      bad_q < 8'h28 || lat_q < 8'h3c) else $error("lock lost without cause");
endmodule : ssp_props

// [sim/host_model.sv]
// host controller model driving the three-wire programming pins
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk, // bench clock
   output logic serial_clk, // serial clock, still low between words
   output logic serial_data, // serial data
   output logic latch_strobe // latch strobe
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      latch_strobe = 1'b0;
   end
   task automatic half();
      repeat (16) @(posedge sys_clk);
      #1;
   endtask : half
   // data moves only while the clock is low, so it is settled at the rise
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         half();
         serial_clk = 1'b1;
         half();
         serial_clk = 1'b0;
      end
      half();
      latch_strobe = 1'b1;
      serial_data = ~w[0];
      half();
      half();
      latch_strobe = 1'b0;
   endtask : send
endmodule : host_model

// [sim/synth_serial_program_port_tb.sv]
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module synth_serial_program_port_tb;
   logic sys_clk, rstn, clk_en, pd_clk, serial_clk, serial_data;
   logic latch_strobe, status_output_pin, lock_detect, fast_lock;
   logic prescaler_sel;
   logic [7:0] err_ns, err_set;
   synth_prog_pkg::divider_cfg_t divider_cfg, dq[$];
   logic [8:0] timeout_count;
   logic [1:0] timer_sel;
   logic [4:0] powerdown_ctl;
   logic [23:0] function_word, mw, pw, r;
   logic [16:0] bexp, bq[$];
   int errors, n_compared;
   integer seed = 32'h3e0d29c0;
   synth_serial_program_port u_dut (.sys_clk(sys_clk), .rstn(rstn),
      .clk_en(clk_en), .serial_clk(serial_clk), .serial_data(serial_data),
      .latch_strobe(latch_strobe), .phase_detector_clk(pd_clk),
      .phase_error_ns(err_ns), .status_output_pin(status_output_pin),
      .lock_detect(lock_detect), .fast_lock(fast_lock),
      .divider_cfg(divider_cfg), .prescaler_sel(prescaler_sel),
      .timeout_count(timeout_count), .timer_sel(timer_sel),
      .powerdown_ctl(powerdown_ctl), .function_word(function_word));
   host_model u_host (.sys_clk(sys_clk), .serial_clk(serial_clk),
      .serial_data(serial_data), .latch_strobe(latch_strobe));
   task automatic chk(input string nm, input logic [63:0] e, g);
      n_compared++;
      if (e !== g) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // note the expected effect of each word, then shift it in
   task automatic wr(input logic [23:0] w);
      case (w[2:0])
         3'h0: dq.push_back('{w[23:15], w[14:3], mw[14:3], mw[18:15],
            mw[23], mw[22], mw[19], pw[14:3]});
         3'h1: begin
            mw = w;
            bexp[16] = w[20];
         end
         3'h2: pw = w;
         3'h4: bexp[15:5] = w[13:3];
         3'h5: bexp[4:0] = w[7:3];
         default: ;
      endcase
      bq.push_back(bexp);
      u_host.send(w);
   endtask : wr
   task automatic wait_lock(input logic e, input int n);
      for (int i = 0; i < n && lock_detect !== e; i++)
         @(posedge sys_clk) #1;
      chk("lock_detect", 64'(e), 64'(lock_detect));
      if (lock_detect !== e)
         close_out();
      repeat (2) @(posedge sys_clk) #1;
   endtask : wait_lock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // detector error is changed only while its clock is low
   initial begin
      pd_clk = 1'b0;
      err_ns = 8'h00;
      forever begin
         repeat (8) @(posedge sys_clk);
         #1 pd_clk = ~pd_clk;
         if (!pd_clk)
            err_ns = err_set + 8'($unsigned($random(seed)) % 3);
      end
   end
   initial forever begin
      @(posedge latch_strobe);
      repeat (10) @(posedge sys_clk) #1;
      chk("bank", 64'(bq.pop_front()), 64'({prescaler_sel, timeout_count,
         timer_sel, powerdown_ctl}));
   end
   initial forever begin
      @(posedge fast_lock);
      repeat (2) @(posedge sys_clk);
      chk("divider_cfg", 64'(dq.pop_front()), 64'(divider_cfg));
   end
   initial begin
      {errors, n_compared} = '0;
      {rstn, bexp, mw, pw} = '0;
      clk_en = 1'b1;
      err_set = 8'h1f;
      repeat (8) @(posedge sys_clk);
      #1 rstn = 1'b1;
      r = $random(seed);
      wr({r[23:22], 1'b0, r[20:3], 3'h1});
      r = $random(seed);
      wr({9'h000, r[14:3], 3'h2});
      chk("shadow", 64'h0, 64'(divider_cfg));
      r = $random(seed);
      wr({9'h000, 1'b1, r[13:3], 3'h4});
      r = $random(seed);
      wr({16'h0000, r[7:3], 3'h5});
      wr(24'h000053);
      chk("function_word", 64'h53, 64'(function_word));
      wr(24'h000007);
      wr(24'h0000b6);
      err_set = 8'h00;
      r = $random(seed);
      wr({r[23:3], 3'h0});
      repeat (576) @(posedge sys_clk) #1;
      chk("early_lock", 64'h0, 64'(lock_detect));
      wait_lock(1'b1, 300);
      chk("status", 64'h1, 64'(status_output_pin));
      // a large error while frozen must not reach the lock state
      err_set = 8'h1f;
      clk_en = 1'b0;
      repeat (200) @(posedge sys_clk) #1;
      chk("frozen_lock", 64'h1, 64'(lock_detect));
      err_set = 8'h00;
      repeat (40) @(posedge sys_clk) #1;
      clk_en = 1'b1;
      repeat (40) @(posedge sys_clk) #1;
      chk("thawed_lock", 64'h1, 64'(lock_detect));
      err_set = 8'h1f;
      wait_lock(1'b0, 64);
      err_set = 8'h00;
      wait_lock(1'b1, 800);
      err_set = 8'h05;
      r = $random(seed);
      wr({r[23:3], 3'h0});
      chk("new_channel", 64'h0, 64'(lock_detect));
      repeat (720) @(posedge sys_clk) #1;
      chk("tight_lock", 64'h0, 64'(lock_detect));
      wr(24'h0080b6);
      wait_lock(1'b1, 800);
      err_set = 8'h1f;
      wait_lock(1'b0, 64);
      wr(24'h0000fe);
      chk("status_high", 64'h1, 64'(status_output_pin));
      wr(24'h000086);
      chk("status_low", 64'h0, 64'(status_output_pin));
      chk("pending", 64'h0, 64'(dq.size() + bq.size()));
      close_out();
   end
endmodule : synth_serial_program_port_tb
bind synth_serial_program_port ssp_props u_props (.sys_clk(sys_clk),
   .rstn(rstn), .clk_en(clk_en), .latch_strobe(latch_strobe),
   .phase_error_ns(phase_error_ns), .lock_detect(lock_detect),
   .fast_lock(fast_lock), .divider_cfg(divider_cfg),
   .timeout_count(timeout_count), .function_word(function_word));
